/* File: rtl/mprs_pkg.sv */
// Purpose: shared constants and types for the power-off and reset sequencer
// Assumes: 100 MHz clock
// Notes:   times kept in their own unit, reset cycle count derived from them; REG_STEP_CYC given in cycles
package mprs_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned HWRST_MIN_MS    = 50;
  localparam int unsigned HWRST_MIN_CYC   = HWRST_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned SWON_HOLD_MS    = 5;
  localparam int unsigned NREG            = 4;
  localparam int unsigned REG_STEP_CYC    = 16;
  localparam int unsigned CNT_W           = 32;
  localparam logic [NREG-1:0] REG_ALL_ON  = 4'hF;
  localparam logic [NREG-1:0] REG_ALL_OFF = 4'h0;

  typedef enum logic [3:0] {
    MPRS_OFF,
    MPRS_PWRUP,
    MPRS_RUN,
    MPRS_SAVE,
    MPRS_DETACH,
    MPRS_REGDOWN,
    MPRS_NOPWR,
    MPRS_HWRST
  } mprs_state_t;
endpackage : mprs_pkg

/* File: rtl/mprs_seq.sv */
// Purpose: power-off, under-voltage and reset sequencing of a modem module
// Assumes: host keeps the reset and switch-on pins at defined levels
// Notes:   single clock; the counting domain is treated as always on
// Operation
// R1: power-off command is acknowledged, then settings saved, detach, pins tri-stated
// R2: sequencer waits for detach done, however long it takes
// R3: after routine pins stay tri-stated, regulators drop in order, backup stays on
// R4: power-off mode held until switch-on falling edge or rtc alarm
// R5: supply loss while powered off enters not-powered mode
// R6: supply loss shuts down without saving or detaching
// R7: hardware reset only after reset line low at least 50 ms
// R8: hardware reset clears all but rtc, interface supply off, pins tri-stated
// R9: hardware reset neither saves settings nor detaches
// R10: function reset resets baseband only; interface supply on, pins reset state
// R11: software reset saves and detaches before power-on sequence
// R12: reset line release starts power-on sequence
// R13: host holds reset line at defined level always
// R14: host powers off by command, not by removing supply
// R15: host holds switch-on low at least 5 ms after falling edge
// R16: reset low time counted in always-on domain; short pulses ignored
`timescale 1ns/1ps
`default_nettype none
module mprs_seq
  import mprs_pkg::*;
#(
  parameter int unsigned HWRST_CYC = HWRST_MIN_CYC  // shorten in simulation
)(
  input  wire logic            clk,              // 100 MHz clock
  input  wire logic            rstn,             // sync reset, active low
  input  wire logic            hw_reset_n,       // reset pin, async, active low
  input  wire logic            switch_on_request,// switch-on pin, async
  input  wire logic            rtc_alarm,        // alarm from rtc domain
  input  wire logic            supply_ok,        // main supply present, async
  input  wire logic            power_off_command,// command pulse
  input  wire logic            function_reset_command, // command pulse
  input  wire logic            save_done,        // nv save finished pulse
  input  wire logic            detach_done,      // network detach finished pulse
  output logic                 cmd_ok,           // ok answer pulse
  output logic                 save_req,         // request nv save, level
  output logic                 detach_req,       // request detach, level
  output logic                 pins_tristate,    // digital pins floated
  output logic                 pins_reset_state, // digital pins in reset state
  output logic                 bb_reset_n,       // baseband reset, active low
  output logic                 pmu_reset_n,      // pmu reset, active low
  output logic                 if_supply_en,     // interface supply enable
  output logic                 backup_supply,    // rtc backup supply enable
  output logic [NREG-1:0]      reg_en,           // internal regulators
  output logic                 powered_off       // in power-off or not-powered mode
);

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  logic rst_s1_q, rst_s2_q, son_s1_q, son_s2_q, son_d_q, sup_s1_q, sup_s2_q;
  always_ff @(posedge clk)
  begin
    rst_s1_q <= hw_reset_n;
    rst_s2_q <= rst_s1_q;
    son_s1_q <= switch_on_request;
    son_s2_q <= son_s1_q;
    son_d_q  <= son_s2_q;
    sup_s1_q <= supply_ok;
    sup_s2_q <= sup_s1_q;
  end
  wire logic son_fall = son_d_q & ~son_s2_q;

  // --------------------------------------------------------------
  // reset low-time measurement
  // --------------------------------------------------------------
  // runs regardless of rstn: it lives with the rtc and must not clear
  logic [CNT_W-1:0] low_cnt_q;
  logic             hwrst_q;
  always_ff @(posedge clk)
  begin
    if (rst_s2_q)
      low_cnt_q <= '0;                                           // see R16
    else if (low_cnt_q < CNT_W'(HWRST_CYC))
      low_cnt_q <= low_cnt_q + CNT_W'(1);
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
      hwrst_q <= 1'b0;
    else if (rst_s2_q)
      hwrst_q <= 1'b0;
    else if (low_cnt_q >= CNT_W'(HWRST_CYC - 1))
      hwrst_q <= 1'b1;                                           // see R7
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  mprs_state_t      st_q;
  logic             swrst_q;
  logic [7:0]       step_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_q    <= MPRS_OFF;
      swrst_q <= 1'b0;
      step_q  <= '0;
      cmd_ok  <= 1'b0;
      reg_en  <= REG_ALL_OFF;
    end
    else
    begin
      cmd_ok <= 1'b0;
      if (!sup_s2_q)
      begin
        st_q    <= MPRS_NOPWR;                                   // see R5 R6
        swrst_q <= 1'b0;
        reg_en  <= REG_ALL_OFF;
      end
      else if (hwrst_q)
      begin
        st_q    <= MPRS_HWRST;                                   // see R8 R9
        swrst_q <= 1'b0;
        reg_en  <= REG_ALL_OFF;
      end
      else
      begin
        case (st_q)
          MPRS_OFF:
            if (son_fall || rtc_alarm)
              st_q <= MPRS_PWRUP;                                // see R4
          MPRS_HWRST:
            st_q <= MPRS_PWRUP;                                  // see R12
          MPRS_NOPWR:
            st_q <= MPRS_PWRUP;
          MPRS_PWRUP:
          begin
            // reset-state pins shown once; a later power-up must not repeat them
            swrst_q <= 1'b0;
            reg_en  <= REG_ALL_ON;
            st_q    <= MPRS_RUN;
          end
          MPRS_RUN:
            if (power_off_command)
            begin
              cmd_ok  <= 1'b1;                                   // see R1
              swrst_q <= 1'b0;
              st_q    <= MPRS_SAVE;
            end
            else if (function_reset_command)
            begin
              cmd_ok  <= 1'b1;
              swrst_q <= 1'b1;                                   // see R11
              st_q    <= MPRS_SAVE;
            end
          MPRS_SAVE:
            if (save_done)
              st_q <= MPRS_DETACH;
          MPRS_DETACH:
            if (detach_done)
            begin
              step_q <= '0;
              st_q   <= swrst_q ? MPRS_PWRUP : MPRS_REGDOWN;     // see R2 R11
            end
          MPRS_REGDOWN:
          begin
            // one regulator dropped every step, highest index first
            step_q <= step_q + 8'h01;
            if (step_q == 8'(REG_STEP_CYC - 1))
            begin
              step_q <= '0;
              if (reg_en == REG_ALL_OFF)
                st_q <= MPRS_OFF;
              else
                reg_en <= reg_en >> 1;                           // see R3
            end
          end
          default:
            st_q <= MPRS_OFF;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // pin and supply outputs
  // --------------------------------------------------------------
  wire logic in_sw   = swrst_q && (st_q == MPRS_SAVE || st_q == MPRS_DETACH);
  wire logic routine = !swrst_q && (st_q == MPRS_SAVE || st_q == MPRS_DETACH);
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      save_req         <= 1'b0;
      detach_req       <= 1'b0;
      pins_tristate    <= 1'b1;
      pins_reset_state <= 1'b0;
      bb_reset_n       <= 1'b0;
      pmu_reset_n      <= 1'b0;
      if_supply_en     <= 1'b0;
      powered_off      <= 1'b1;
    end
    else
    begin
      // supply loss or hardware reset drops a pending request at once
      save_req         <= (st_q == MPRS_SAVE) && !save_done && sup_s2_q && !hwrst_q;
      detach_req       <= (st_q == MPRS_DETACH) && !detach_done && sup_s2_q
                          && !hwrst_q;                               // see R6 R9
      pins_tristate    <= !(st_q == MPRS_RUN || in_sw);          // see R1 R3 R8
      pins_reset_state <= (st_q == MPRS_PWRUP) && swrst_q;       // see R10
      bb_reset_n       <= (st_q == MPRS_RUN) || routine || in_sw;
      pmu_reset_n      <= !(hwrst_q || st_q == MPRS_HWRST);      // see R8
      if_supply_en     <= (st_q == MPRS_RUN) || routine || in_sw
                          || ((st_q == MPRS_PWRUP) && swrst_q);  // see R10
      powered_off      <= (st_q == MPRS_OFF) || (st_q == MPRS_NOPWR);
    end
  end
  assign backup_supply = 1'b1;                                   // see R3 R8

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_short_low;
    @(posedge clk) disable iff (!rstn)
    (low_cnt_q < CNT_W'(HWRST_CYC - 1)) |=> !hwrst_q || $past(hwrst_q);
  endproperty
  a_short_low: assert property (p_short_low) else $error("short pulse reset"); // see R16
  property p_ok;
    @(posedge clk) disable iff (!rstn)
    (st_q == MPRS_RUN && power_off_command && sup_s2_q && !hwrst_q) |=> cmd_ok;
  endproperty
  a_ok: assert property (p_ok) else $error("no ok answer"); // see R1
  property p_wait_detach;
    @(posedge clk) disable iff (!rstn)
    (st_q == MPRS_DETACH && !detach_done && sup_s2_q && !hwrst_q) |=> st_q == MPRS_DETACH;
  endproperty
  a_wait_detach: assert property (p_wait_detach) else $error("left before detach"); // see R2
  property p_off_tri;
    @(posedge clk) disable iff (!rstn)
    (st_q == MPRS_REGDOWN) |=> pins_tristate;
  endproperty
  a_off_tri: assert property (p_off_tri) else $error("pins driven in shutdown"); // see R3
  property p_hold_off;
    @(posedge clk) disable iff (!rstn)
    (st_q == MPRS_OFF && !son_fall && !rtc_alarm && sup_s2_q && !hwrst_q) |=> st_q == MPRS_OFF;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("left power-off"); // see R4
  property p_nopwr;
    @(posedge clk) disable iff (!rstn)
    !sup_s2_q |=> st_q == MPRS_NOPWR && !save_req ##1 !detach_req;
  endproperty
  a_nopwr: assert property (p_nopwr) else $error("no not-powered entry"); // see R5
  property p_hw;
    @(posedge clk) disable iff (!rstn)
    hwrst_q && sup_s2_q |=> st_q == MPRS_HWRST ##1 !pmu_reset_n && pins_tristate;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware reset effect wrong"); // see R8
  property p_sw;
    @(posedge clk) disable iff (!rstn)
    (st_q == MPRS_PWRUP && swrst_q && !hwrst_q) |=> if_supply_en && pmu_reset_n;
  endproperty
  a_sw: assert property (p_sw) else $error("software reset effect wrong"); // see R10
  c_poweroff: cover property (@(posedge clk) st_q == MPRS_REGDOWN ##[1:200] st_q == MPRS_OFF);
  c_swrst:    cover property (@(posedge clk) st_q == MPRS_DETACH && swrst_q && detach_done);
  c_hwrst:    cover property (@(posedge clk) st_q == MPRS_HWRST);
endmodule : mprs_seq
`default_nettype wire

/* File: tb/mprs_host.sv */
// Purpose: host-side model answering the save and detach requests
// Assumes: requests are levels held until their done pulse is seen
// Notes:   the answer delay is set per test so the host can be prompt or slow
`timescale 1ns/1ps
`default_nettype none
module mprs_host (
  input  wire logic       clk,         // 100 MHz clock
  input  wire logic       save_req,    // nv save wanted
  input  wire logic       detach_req,  // detach wanted
  input  wire logic [7:0] dly,         // answer delay in cycles
  output logic            save_done,   // save finished pulse
  output logic            detach_done  // detach finished pulse
);
  logic [7:0] s_q;
  logic [7:0] d_q;

  // one pulse per request; a late detach shows whether the sequencer really waits
  always_ff @(posedge clk)
  begin
    save_done   <= save_req && s_q == dly;
    detach_done <= detach_req && d_q == dly;
    s_q         <= !save_req ? 8'h00 : (s_q <= dly ? s_q + 8'h01 : s_q);
    d_q         <= !detach_req ? 8'h00 : (d_q <= dly ? d_q + 8'h01 : d_q);
  end
endmodule : mprs_host
`default_nettype wire

/* File: tb/mprs_seq_tb.sv */
// Purpose: self-checking bench for the power-off and reset sequencer
// Assumes: reset low time shortened to 20 cycles
// Notes:   host pins are always driven to a defined level, never floated
`timescale 1ns/1ps
`default_nettype none
module mprs_seq_tb;
  import mprs_pkg::*;
  typedef struct {logic op; logic [7:0] dly; logic [19:0] sq; logic tr;} mprs_row_t;
  localparam int unsigned HW = 20;
  logic clk, rstn, hrn, swon, alarm, sup, pcmd, fcmd, sdone, ddone;
  logic cok, sreq, dreq, tri_o, prs, bbn, pmun, ifs, bck, poff;
  logic [NREG-1:0] reg_en;
  logic [7:0]      dly;
  int              failures, check_count, n;
  mprs_row_t rows [4] = '{'{1'h0, 8'h00, 20'hF7310, 1'h1}, '{1'h0, 8'h28, 20'hF7310, 1'h1},
                          '{1'h1, 8'h00, 20'h0000F, 1'h0}, '{1'h1, 8'h28, 20'h0000F, 1'h0}};

  mprs_seq #(.HWRST_CYC(HW)) dut (.clk(clk), .rstn(rstn), .hw_reset_n(hrn),
    .switch_on_request(swon), .rtc_alarm(alarm), .supply_ok(sup), .power_off_command(pcmd),
    .function_reset_command(fcmd), .save_done(sdone), .detach_done(ddone), .cmd_ok(cok),
    .save_req(sreq), .detach_req(dreq), .pins_tristate(tri_o), .pins_reset_state(prs),
    .bb_reset_n(bbn), .pmu_reset_n(pmun), .if_supply_en(ifs), .backup_supply(bck),
    .reg_en(reg_en), .powered_off(poff));
  mprs_host host (.clk(clk), .save_req(sreq), .detach_req(dreq), .dly(dly),
    .save_done(sdone), .detach_done(ddone));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task step;
    @(posedge clk);
    #1;
  endtask : step

  // ev asks for a switch-on edge; the pin is held low for 8 cycles only, far below the host's 5 ms minimum hold
  task up(input logic ev);
    if (ev)
    begin
      swon = 1'h0;
      repeat (8) step;
      swon = 1'h1;
    end
    n = 0;
    while (!(bbn === 1'h1 && pmun === 1'h1 && tri_o === 1'h0 && prs === 1'h0 && poff === 1'h0)
           && n < 3000)
    begin
      step;
      n++;
    end
    chk(n < 3000, 20'h1, "power up");
  endtask : up

  task run_row(input mprs_row_t r);
    logic       ok, sv, early, tmax, ifs_lo, pmu_lo, bb_lo;
    logic [3:0] last;
    logic [19:0] sq;
    up(1'h1);
    dly = r.dly;
    {ok, sv, early, tmax, ifs_lo, pmu_lo, bb_lo} = 7'h00;
    last = reg_en;
    sq = {16'h0000, reg_en};
    if (r.op) fcmd = 1'h1;
    else pcmd = 1'h1;
    n = 0;
    while (n < 900 && !(r.op ? prs === 1'h1 : poff === 1'h1))
    begin
      step;
      n++;
      {pcmd, fcmd} = 2'h0;
      ok |= cok === 1'h1;
      sv |= sreq === 1'h1;
      if (dreq === 1'h1) {early, tmax} = {early | (reg_en !== 4'hF), tmax | tri_o};
      if (reg_en !== last) {sq, last} = {sq[15:0], reg_en, reg_en};
      {ifs_lo, pmu_lo, bb_lo} = {ifs_lo | (ifs !== 1'h1), pmu_lo | (pmun !== 1'h1),
                                 bb_lo | (bbn !== 1'h1)};
    end
    chk({ok, sv, early}, 20'h6, "answer, save, wait");
    chk(tmax, r.tr, "pins during detach");
    chk(sq, r.sq, "regulator order");
    chk(bck, 20'h1, "backup supply");
    if (r.op) chk({ifs_lo, pmu_lo, bb_lo}, 20'h1, "baseband only");
    else
    begin
      repeat (50) step;
      chk({poff, tri_o}, 20'h3, "stays off");
    end
    $display("row op %0d delay %0d done", r.op, r.dly);
  endtask : run_row

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("[ERR] %0t run did not finish", $time);
    results;
  end

  initial
  begin
    {rstn, pcmd, fcmd, alarm} = 4'h0;
    {hrn, swon, sup} = 3'h7;
    dly = 8'h00;
    repeat (5) step;
    rstn = 1'h1;
    repeat (3) step;
    foreach (rows[i]) run_row(rows[i]);
    hrn = 1'h0;
    repeat (HW - 10) step;
    hrn = 1'h1;
    repeat (30) step;
    chk(pmun, 20'h1, "short reset pulse");
    $display("short pulse done");
    hrn = 1'h0;
    repeat (HW + 10) step;
    chk({pmun, tri_o, ifs, bck, sreq, dreq, reg_en}, 20'h140, "hw reset");
    hrn = 1'h1;
    up(1'h0);
    $display("hw reset done");
    // supply lost while the slow host is still saving: nothing may be saved or detached
    dly = 8'h28;
    pcmd = 1'h1;
    step;
    pcmd = 1'h0;
    repeat (4) step;
    chk(sreq, 20'h1, "save under way");
    sup = 1'h0;
    repeat (10) step;
    chk({poff, sreq, dreq}, 20'h4, "supply loss");
    sup = 1'h1;
    up(1'h0);
    run_row(rows[0]);
    alarm = 1'h1;
    step;
    alarm = 1'h0;
    up(1'h0);
    run_row(rows[0]);
    sup = 1'h0;
    repeat (10) step;
    sup = 1'h1;
    up(1'h0);
    $display("supply and alarm done");
    rstn = 1'h0;
    repeat (2) step;
    chk({poff, tri_o, pmun, bbn, ifs, cok, reg_en}, 20'h300, "reset values");
    rstn = 1'h1;
    repeat (3) step;
    chk({poff, tri_o}, 20'h3, "off after reset");
    $display("reset done");
    results;
  end
endmodule : mprs_seq_tb
`default_nettype wire
